/* File: rtl/sqfl_params.svh */
// Constants of the supply sequencer fault logic.
// Assumes a 100 MHz MCLK; included by bare name.
`ifndef SQFL_PARAMS_SVH
`define SQFL_PARAMS_SVH
`define SQFL_CLK_MHZ 100
`define SQFL_SAMPLE_US 20
`define SQFL_SAMPLE_CYC (`SQFL_SAMPLE_US * `SQFL_CLK_MHZ)
`define SQFL_FAST_US 1
`define SQFL_FAST_CYC (`SQFL_FAST_US * `SQFL_CLK_MHZ)
`define SQFL_STEP_CYC 16
`define SQFL_CHANNELS 4
`endif

/* File: rtl/sqfl_pkg.sv */
// Types of the supply sequencer fault logic.
// Assumes nothing beyond the parameter header.
package sqfl_pkg;
    typedef enum logic [2:0] {
        SQFL_IDLE = 3'b000,
        SQFL_UP = 3'b001,
        SQFL_ON = 3'b010,
        SQFL_DOWN = 3'b011,
        SQFL_FAULT = 3'b100
    } sqfl_state_t;
endpackage

/* File: rtl/sqfl_sync.sv */
// Three-flop input synchroniser with agreement of stages two and three.
// Assumes an asynchronous pin level at din.
`timescale 1ns/1ps
module sqfl_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_r, s2_r, s3_r, out_r;
    logic [W-1:0] out_nxt;
    always_comb begin
        out_nxt = out_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                out_nxt[i] = s3_r[i];
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end
    assign dout = out_r;
endmodule

/* File: rtl/sqfl_filter.sv */
// Per-channel persistence counter: output rises after LEN cycles of input high.
// Assumes a synchronised input on the same clock.
`timescale 1ns/1ps
module sqfl_filter #(
    parameter int LEN = 100
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic hit
);
    logic [15:0] cnt_r, cnt_nxt;
    logic hit_r, hit_nxt;
    always_comb begin
        cnt_nxt = din ? cnt_r + 16'h0001 : 16'h0000;
        hit_nxt = 1'b0;
        if (din && cnt_r >= 16'(LEN - 1)) begin
            cnt_nxt = cnt_r;
            hit_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            hit_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            hit_r <= hit_nxt;
        end
    end
    assign hit = hit_r;
endmodule

/* File: rtl/sqfl_core.sv */
// Fault detection and handling of a four-channel supply sequencer.
// Assumes comparator outputs as digital pins; pins sync'd inside.
`timescale 1ns/1ps
`include "sqfl_params.svh"
module sqfl_core
    import sqfl_pkg::*;
#(
    parameter int CH = `SQFL_CHANNELS,
    parameter int SAMPLE_CYC = `SQFL_SAMPLE_CYC,
    parameter int FAST_CYC = `SQFL_FAST_CYC,
    parameter int STEP_CYC = `SQFL_STEP_CYC
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic RAIL_REQUEST,
    input wire logic [3:0] SUPPLY_SENSE,
    input wire logic [3:0] SENSE_FAST_LOW,
    input wire logic WATCHDOG_OVER,
    input wire logic WATCHDOG_GROUNDED,
    input wire logic SHARED_ERROR_IN,
    output logic SHARED_ERROR_OE,
    output logic SHARED_ERROR_OUT,
    output logic [3:0] RAIL_ENABLE,
    output logic SEQ_COMPLETE_N,
    output logic DELAY_TIMER_OUT,
    output logic DELAY_TIMER_OE
);
    logic req_s, wdg_s, wdg_gnd_s, err_low_s;
    logic [3:0] sense_s, fast_s, fast_hit;
    sqfl_sync #(.W(11)) u_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        // Fault line enters inverted so that the reset value means line released
        .din({RAIL_REQUEST, WATCHDOG_OVER, WATCHDOG_GROUNDED, ~SHARED_ERROR_IN, SUPPLY_SENSE, SENSE_FAST_LOW[2:0]}),
        .dout({req_s, wdg_s, wdg_gnd_s, err_low_s, sense_s, fast_s[2:0]})
    );
    logic fast3_s;
    sqfl_sync #(.W(1)) u_sync_f3 (
        .clk(MCLK),
        .rst_n(RST_N),
        .din(SENSE_FAST_LOW[3]),
        .dout(fast3_s)
    );
    assign fast_s[3] = fast3_s;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_fast
            sqfl_filter #(.LEN(FAST_CYC / 4)) u_filt (
                .clk(MCLK),
                .rst_n(RST_N),
                .din(fast_s[g] & RAIL_ENABLE[g]),
                .hit(fast_hit[g])
            );
        end
    endgenerate
    sqfl_state_t st_r, st_nxt;
    logic [3:0] en_r, en_nxt;
    logic [3:0] expect_r, expect_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [15:0] step_r, step_nxt;
    logic [15:0] smp_r, smp_nxt;
    logic done_r, done_nxt;
    logic ext_r, ext_nxt;
    logic err_oe_r, err_oe_nxt;
    logic tmr_oe_r, tmr_oe_nxt, tmr_out_r, tmr_out_nxt;
    logic hold_r, hold_nxt;
    logic seq_n_r;
    logic sample_tick, seq_err, req_err, wdg_err, int_fault, ext_fault, fault_quiet, clear_ok;
    always_comb begin
        sample_tick = (smp_r == 16'(SAMPLE_CYC - 1));
        smp_nxt = sample_tick ? 16'h0000 : smp_r + 16'h0001;
        seq_err = (sample_tick && |(expect_r & ~sense_s)) || |(expect_r & fast_hit);
        req_err = (st_r == SQFL_UP && !req_s) || (st_r == SQFL_DOWN && req_s);
        wdg_err = (st_r == SQFL_UP) && wdg_s && !wdg_gnd_s;
        int_fault = seq_err || req_err || wdg_err;
        ext_fault = err_low_s && !err_oe_r;
        fault_quiet = (sense_s == 4'h0) && !req_s;
        // Own pull is released first; the line must then be seen free before the clear
        clear_ok = fault_quiet && !err_oe_r && !err_low_s;
    end
    always_comb begin
        st_nxt = st_r;
        en_nxt = en_r;
        expect_nxt = expect_r;
        idx_nxt = idx_r;
        step_nxt = (step_r != 16'h0000) ? step_r - 16'h0001 : 16'h0000;
        done_nxt = done_r;
        ext_nxt = ext_r;
        err_oe_nxt = err_oe_r;
        hold_nxt = hold_r;
        unique case (st_r)
            SQFL_IDLE: begin
                if (req_s) begin
                    st_nxt = SQFL_UP;
                    idx_nxt = 3'h0;
                    en_nxt = 4'h1;
                end
            end
            SQFL_UP: begin
                if (sense_s[idx_r[1:0]] && en_r[idx_r[1:0]]) begin
                    expect_nxt[idx_r[1:0]] = 1'b1;
                    if (idx_r == 3'h3) begin
                        st_nxt = SQFL_ON;
                        done_nxt = 1'b1;
                    end else if (step_r == 16'h0000) begin
                        step_nxt = 16'(STEP_CYC);
                        idx_nxt = idx_r + 3'h1;
                    end
                end
                if (idx_r != 3'h0 && !en_r[idx_r[1:0]] && step_r == 16'h0001) begin
                    en_nxt[idx_r[1:0]] = 1'b1;
                end
            end
            SQFL_ON: begin
                if (!req_s) begin
                    st_nxt = SQFL_DOWN;
                    idx_nxt = 3'h3;
                    en_nxt[3] = 1'b0;
                    expect_nxt[3] = 1'b0;
                end
            end
            SQFL_DOWN: begin
                if (!sense_s[idx_r[1:0]] && step_r == 16'h0000) begin
                    if (idx_r == 3'h0) begin
                        st_nxt = SQFL_IDLE;
                        done_nxt = 1'b0;
                    end else begin
                        idx_nxt = idx_r - 3'h1;
                        step_nxt = 16'(STEP_CYC);
                    end
                end
                if (step_r == 16'h0001) begin
                    en_nxt[idx_r[1:0]] = 1'b0;
                    expect_nxt[idx_r[1:0]] = 1'b0;
                end
            end
            SQFL_FAULT: begin
                err_oe_nxt = !fault_quiet;
                if (clear_ok) begin
                    st_nxt = SQFL_IDLE;
                    ext_nxt = 1'b0;
                end
            end
            default: st_nxt = SQFL_FAULT;
        endcase
        if (st_r != SQFL_FAULT && (int_fault || ext_fault)) begin
            st_nxt = SQFL_FAULT;
            en_nxt = 4'h0;
            expect_nxt = 4'h0;
            done_nxt = 1'b0;
            err_oe_nxt = 1'b1;
            ext_nxt = !int_fault;
            hold_nxt = req_s;
        end
        if (hold_r && !req_s) begin
            hold_nxt = 1'b0;
        end
    end
    always_comb begin
        tmr_oe_nxt = 1'b0;
        tmr_out_nxt = 1'b0;
        if (st_r == SQFL_FAULT || hold_r) begin
            tmr_oe_nxt = 1'b1;
            tmr_out_nxt = !ext_r;
        end
    end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r <= SQFL_IDLE;
            en_r <= 4'h0;
            expect_r <= 4'h0;
            idx_r <= 3'h0;
            step_r <= 16'h0000;
            smp_r <= 16'h0000;
            done_r <= 1'b0;
            seq_n_r <= 1'b1;
            ext_r <= 1'b0;
            err_oe_r <= 1'b0;
            hold_r <= 1'b0;
            tmr_oe_r <= 1'b0;
            tmr_out_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            en_r <= en_nxt;
            expect_r <= expect_nxt;
            idx_r <= idx_nxt;
            step_r <= step_nxt;
            smp_r <= smp_nxt;
            done_r <= done_nxt;
            seq_n_r <= !done_nxt;
            ext_r <= ext_nxt;
            err_oe_r <= err_oe_nxt;
            hold_r <= hold_nxt;
            tmr_oe_r <= tmr_oe_nxt;
            tmr_out_r <= tmr_out_nxt;
        end
    end
    assign RAIL_ENABLE = en_r;
    assign SHARED_ERROR_OE = err_oe_r;
    assign SHARED_ERROR_OUT = 1'b0;
    assign SEQ_COMPLETE_N = seq_n_r;
    assign DELAY_TIMER_OE = tmr_oe_r;
    assign DELAY_TIMER_OUT = tmr_out_r;

    chk_fault_drops_rails: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_r != SQFL_FAULT && st_nxt == SQFL_FAULT) |=> (RAIL_ENABLE == 4'h0))
        else $error("Rails not dropped on fault");
    chk_fault_pulls_line: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_r == SQFL_FAULT && !fault_quiet) |=> SHARED_ERROR_OE)
        else $error("Error line not pulled in fault");
    chk_entry_pulls_line: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_r != SQFL_FAULT && st_nxt == SQFL_FAULT) |=> SHARED_ERROR_OE)
        else $error("Error line not pulled on fault entry");
    chk_clear_needs_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_r == SQFL_FAULT && st_nxt == SQFL_IDLE) |-> (sense_s == 4'h0 && !req_s && !err_low_s))
        else $error("Fault cleared without quiet inputs");
    chk_ext_indicator: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_r == SQFL_FAULT && ext_r) |=> (DELAY_TIMER_OE && !DELAY_TIMER_OUT))
        else $error("External indicator wrong");
    chk_int_indicator: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_r == SQFL_FAULT && !ext_r) |=> (DELAY_TIMER_OE && DELAY_TIMER_OUT))
        else $error("Internal indicator wrong");
    chk_early_drop: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_r == SQFL_UP && !req_s) |=> (st_r == SQFL_FAULT) ##1 (RAIL_ENABLE == 4'h0))
        else $error("Early request drop not faulted");
    chk_early_rise: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_r == SQFL_DOWN && req_s) |=> (st_r == SQFL_FAULT))
        else $error("Early request rise not faulted");
    chk_watchdog_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_r == SQFL_UP && wdg_s && !wdg_gnd_s) |=> (st_r == SQFL_FAULT && !ext_r))
        else $error("Watchdog timeout missed");
    chk_done_on_last: assert property (@(posedge MCLK) disable iff (!RST_N)
        $fell(SEQ_COMPLETE_N) |-> ($past(st_r) == SQFL_UP && RAIL_ENABLE == 4'hF))
        else $error("Completion without all rails");
endmodule

/* File: verification/sqfl_supply_model.sv */
// Behavioural model of four sequenced supplies with their comparators.
// Assumes rail enables from the sequencer on the same clock.
`timescale 1ns/1ps
module sqfl_supply_model #(
    parameter int RISE_CYC = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] rail_enable,
    input wire logic [3:0] drop_hard,
    input wire logic [3:0] drop_soft,
    output logic [3:0] supply_sense,
    output logic [3:0] sense_fast_low
);
    logic [3:0] up_r;
    int cnt_r [4];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= 4'h0;
            for (int i = 0; i < 4; i++) cnt_r[i] <= 0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!rail_enable[i]) begin
                    cnt_r[i] <= 0;
                    up_r[i] <= 1'b0;
                end else if (cnt_r[i] < RISE_CYC) begin
                    cnt_r[i] <= cnt_r[i] + 1;
                end else begin
                    up_r[i] <= 1'b1;
                end
            end
        end
    end
    // A hard drop falls below both thresholds, a soft one only below the precision one
    assign supply_sense = up_r & ~drop_hard & ~drop_soft;
    assign sense_fast_low = ~up_r | drop_hard;
endmodule

/* File: verification/tb.sv */
// Self-checking bench of the supply sequencer fault logic.
// Assumes the supply model and a pulled-up wired-AND fault line.
`timescale 1ns/1ps
module tb;
    import sqfl_pkg::*;
    localparam int SEQ = 0;
    localparam int FLT = 1;
    localparam int IND = 2;
    logic mclk = 1'b0, rst_n = 1'b0, req = 1'b0, wd_over = 1'b0, wd_gnd = 1'b1, ext_pull = 1'b0;
    logic [3:0] drop_hard = 4'h0, drop_soft = 4'h0, sense, fast_low, rail;
    logic se_oe, se_out, seq_n, dt_out, dt_oe;
    wire logic fault_line = ~(se_oe | ext_pull);
    int err_count = 0, total_checks = 0;
    always #5 mclk = ~mclk;
    // Stand-alone first device of a chain: bias to ground, request node bench-only
    sqfl_core #(.SAMPLE_CYC(20), .FAST_CYC(20), .STEP_CYC(16)) dut (.MCLK(mclk), .RST_N(rst_n),
        .RAIL_REQUEST(req), .SUPPLY_SENSE(sense), .SENSE_FAST_LOW(fast_low), .WATCHDOG_OVER(wd_over),
        .WATCHDOG_GROUNDED(wd_gnd), .SHARED_ERROR_IN(fault_line), .SHARED_ERROR_OE(se_oe),
        .SHARED_ERROR_OUT(se_out), .RAIL_ENABLE(rail), .SEQ_COMPLETE_N(seq_n),
        .DELAY_TIMER_OUT(dt_out), .DELAY_TIMER_OE(dt_oe));
    sqfl_supply_model model (.clk(mclk), .rst_n(rst_n), .rail_enable(rail), .drop_hard(drop_hard),
        .drop_soft(drop_soft), .supply_sense(sense), .sense_fast_low(fast_low));
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    function automatic logic pick(input int w);
        case (w)
            SEQ: return seq_n;
            FLT: return se_oe;
            default: return dt_oe;
        endcase
    endfunction
    // Waits a bounded time for a status output to reach a level, then compares it
    task automatic wait_for(input int w, input logic v, input int lim);
        for (int i = 0; i < lim && pick(w) !== v; i++) @(negedge mclk);
        chk({3'h0, pick(w)}, {3'h0, v});
    endtask
    task automatic wait_rail(input logic [3:0] v, input int lim);
        for (int i = 0; i < lim && rail !== v; i++) @(negedge mclk);
        chk(rail, v);
    endtask
    task automatic power_on();
        req = 1'b1;
        wait_for(SEQ, 1'b0, 400);
        chk(rail, 4'hF);
    endtask
    task automatic clear_fault();
        req = 1'b0;
        drop_hard = 4'h0;
        drop_soft = 4'h0;
        ext_pull = 1'b0;
        wait_for(FLT, 1'b0, 200);
        wait_for(IND, 1'b0, 200);
        cyc(10);
    endtask
    task automatic t_sequence();
        power_on();
        req = 1'b0;
        wait_rail(4'h7, 200);
        wait_for(SEQ, 1'b1, 400);
        chk(rail, 4'h0);
        cyc(10);
    endtask
    task automatic t_supply_drop(input logic hard, input int lim);
        power_on();
        if (hard) drop_hard = 4'h2;
        else drop_soft = 4'h4;
        wait_for(FLT, 1'b1, lim);
        cyc(1);
        chk(rail, 4'h0);
        chk({3'h0, se_out}, 4'h0);
        chk({3'h0, dt_out}, 4'h1);
        cyc(30);
        chk({3'h0, dt_oe}, 4'h1);
        chk(rail, 4'h0);
        clear_fault();
    endtask
    task automatic t_req_errors();
        req = 1'b1;
        wait_rail(4'h1, 40);
        req = 1'b0;
        wait_for(FLT, 1'b1, 20);
        chk(rail, 4'h0);
        clear_fault();
        power_on();
        req = 1'b0;
        wait_rail(4'h7, 200);
        req = 1'b1;
        wait_for(FLT, 1'b1, 20);
        chk(rail, 4'h0);
        clear_fault();
    endtask
    task automatic t_watchdog();
        wd_gnd = 1'b1;
        wd_over = 1'b1;
        power_on();
        chk({3'h0, se_oe}, 4'h0);
        t_sequence();
        wd_gnd = 1'b0;
        req = 1'b1;
        wait_for(FLT, 1'b1, 20);
        cyc(1);
        chk(rail, 4'h0);
        chk({3'h0, dt_out}, 4'h1);
        wd_over = 1'b0;
        clear_fault();
    endtask
    task automatic t_external();
        power_on();
        ext_pull = 1'b1;
        wait_for(FLT, 1'b1, 20);
        cyc(1);
        chk(rail, 4'h0);
        chk({dt_oe, 2'h0, dt_out}, 4'h8);
        ext_pull = 1'b0;
        cyc(10);
        chk({3'h0, se_oe}, 4'h1);
        clear_fault();
    endtask
    initial begin
        #200us;
        err_count++;
        report_and_stop();
    end
    initial begin
        cyc(16);
        rst_n = 1'b1;
        cyc(8);
        t_sequence();
        t_supply_drop(1'b1, 20);
        t_supply_drop(1'b0, 40);
        t_req_errors();
        t_watchdog();
        t_external();
        report_and_stop();
    end
endmodule
